// *** pkg/cpr_map.vh ***
// Constants shared by the CPU register file and its address generator.
// Assumes it is included by bare name, once per design file.
`ifndef CPR_MAP_VH
`define CPR_MAP_VH

// ----
// Reset and fixed values
// ----
`define CPR_IDX_HI_RESET 8'h00
`define CPR_STK_RESET 16'h00ff
`define CPR_STK_LOW_REINIT 8'hff
`define CPR_FETCH_RESET 16'h0000
`define CPR_VEC_HI_ADDR 16'hfffe
`define CPR_VEC_LO_ADDR 16'hffff
`define CPR_DIRECT_PAGE 8'h00

// ----
// Register operations (regOp port)
// ----
`define CPR_OP_NOP 5'h00
`define CPR_OP_LOAD_ACC 5'h01
`define CPR_OP_ALU_WB 5'h02
`define CPR_OP_LOAD_IDX_LO 5'h03
`define CPR_OP_LOAD_IDX_HI 5'h04
`define CPR_OP_CLR_X 5'h05
`define CPR_OP_INC_X 5'h06
`define CPR_OP_DEC_X 5'h07
`define CPR_OP_COM_X 5'h08
`define CPR_OP_NEG_X 5'h09
`define CPR_OP_LSL_X 5'h0a
`define CPR_OP_LSR_X 5'h0b
`define CPR_OP_ASR_X 5'h0c
`define CPR_OP_ROL_X 5'h0d
`define CPR_OP_ROR_X 5'h0e
`define CPR_OP_ACC_TO_X 5'h0f
`define CPR_OP_X_TO_ACC 5'h10
`define CPR_OP_STK_ADJ 5'h11
`define CPR_OP_STK_LOW_REINIT 5'h12
`define CPR_OP_PUSH_ACC 5'h13
`define CPR_OP_PUSH_X 5'h14
`define CPR_OP_PUSH_H 5'h15
`define CPR_OP_PUSH_RET_LO 5'h16
`define CPR_OP_PUSH_RET_HI 5'h17
`define CPR_OP_PUSH_EXT 5'h18
`define CPR_OP_PULL_INC 5'h19
`define CPR_OP_LOAD_FETCH_HI 5'h1a
`define CPR_OP_LOAD_FETCH_LO 5'h1b
`define CPR_OP_LOAD_STK16 5'h1c
`define CPR_OP_LOAD_IDX16 5'h1d
`define CPR_OP_JUMP 5'h1e

// ----
// Addressing modes (addrMode port)
// ----
`define CPR_AM_DIRECT 4'h0
`define CPR_AM_EXTENDED 4'h1
`define CPR_AM_IX 4'h2
`define CPR_AM_IX1 4'h3
`define CPR_AM_IX2 4'h4
`define CPR_AM_IX_POST 4'h5
`define CPR_AM_IX1_POST 4'h6
`define CPR_AM_STK1 4'h7
`define CPR_AM_STK2 4'h8

`endif

// *** rtl/cpr_addr_gen.v ***
// Effective address generator for the CPU register file.
// Assumes pointer inputs come from flops on the same clock; purely combinational.
`include "cpr_map.vh"

module cpr_addr_gen #(
  parameter AW = 16 // Address width
) (
  input wire [3:0] addrMode, // Addressing mode select
  input wire [7:0] opHi, // Operand high byte
  input wire [7:0] opLo, // Operand low byte
  input wire [AW-1:0] hxPtr, // Combined index pointer
  input wire [AW-1:0] stkPtr, // Stack pointer
  output reg [AW-1:0] effAddr, // Computed address
  output reg postInc // Index pointer steps after use
);

  // ----
  // Mode decode
  // ----
  // All index modes use the full 16-bit pointer, never X alone
  always @* begin
    effAddr = hxPtr;
    postInc = 1'b0;
    case (addrMode)
      `CPR_AM_DIRECT: begin
        effAddr = {`CPR_DIRECT_PAGE, opLo}; // see RQ15
      end
      `CPR_AM_EXTENDED: begin
        effAddr = {opHi, opLo}; // see RQ14
      end
      `CPR_AM_IX: begin
        effAddr = hxPtr; // see RQ6
      end
      `CPR_AM_IX1: begin
        effAddr = hxPtr + {8'h00, opLo}; // see RQ6
      end
      `CPR_AM_IX2: begin
        effAddr = hxPtr + {opHi, opLo}; // see RQ17
      end
      `CPR_AM_IX_POST: begin
        effAddr = hxPtr;
        postInc = 1'b1; // see RQ17
      end
      `CPR_AM_IX1_POST: begin
        effAddr = hxPtr + {8'h00, opLo};
        postInc = 1'b1; // see RQ17
      end
      `CPR_AM_STK1: begin
        effAddr = stkPtr + {8'h00, opLo}; // see RQ18
      end
      `CPR_AM_STK2: begin
        effAddr = stkPtr + {opHi, opLo}; // see RQ18
      end
      default: begin
        effAddr = hxPtr;
        postInc = 1'b0;
      end
    endcase
  end

endmodule

// *** rtl/cpr_regs.v ***
// Programmer-visible CPU registers: accumulator, index pair, stack and fetch pointers.
// Assumes an instruction sequencer drives regOp and a memory answers vector reads.
//
// Function
// RQ1: Registers reachable by operations only, no address
// RQ2: Accumulator always feeds one ALU operand
// RQ3: Accumulator loads and stores through any mode
// RQ4: Accumulator keeps its contents through reset
// RQ5: Index pointer is upper and lower byte
// RQ6: Indexed modes use full pointer; some X-only (here every index mode uses the full pointer)
// RQ7: X supports data ops and accumulator transfers
// RQ8: Reset clears upper index byte, keeps lower
// RQ9: Stack pointer names next free location
// RQ10: Calls and interrupts save state on stack
// RQ11: Reset loads stack pointer with low-page top
// RQ12: Stack adjust adds sign-extended byte, 16 bits
// RQ13: Low reinit changes only stack low byte
// RQ14: One 64K space with 16-bit addresses
// RQ15: Direct mode reaches only the lowest page
// RQ16: Relative branch adds signed byte to fetch
// RQ17: Five index submodes, some post-increment
// RQ18: Stack-relative indexed addressing is supported
// RQ19: Fetch pointer steps, loads from reset vector
// RQ20: Pushes use combined stack value, no correction
`include "cpr_map.vh"

module cpr_regs #(
  parameter DW = 8, // Data width
  parameter AW = 16 // Address width
) (
  input wire sys_clk, // System clock
  input wire arst_n, // Async reset, active low
  input wire opValid, // Operation strobe
  input wire [4:0] regOp, // Operation code
  input wire [DW-1:0] opHi, // Operand high byte
  input wire [DW-1:0] opLo, // Operand low byte
  input wire [DW-1:0] memData, // Data read from memory
  input wire [DW-1:0] aluResult, // ALU result for write-back
  input wire [DW-1:0] extPushData, // Condition byte to stack
  input wire carryIn, // Unused; rotate ops take the carry from the last X op
  input wire addrReq, // Request an effective address
  input wire [3:0] addrMode, // Addressing mode for addrReq
  input wire fetchAdv, // Byte fetched, step the pointer
  input wire branchTake, // Take a relative branch
  input wire [DW-1:0] branchOfs, // Signed branch offset
  input wire vecRdValid, // Memory answer for a vector read
  output wire [DW-1:0] aluOperandA, // Accumulator to ALU
  output wire [DW-1:0] storeData, // Accumulator store data
  output wire [AW-1:0] idxPtr, // Combined index pointer
  output wire [AW-1:0] stkPtr, // Stack pointer
  output wire [AW-1:0] nextFetchAddr, // Address of next fetch
  output wire [AW-1:0] effAddr, // Registered effective address
  output wire effValid, // Effective address valid pulse
  output wire xCarryOut, // Carry out of last X op
  output wire stkWrEn, // Stack write pulse
  output wire [AW-1:0] stkWrAddr, // Stack write address
  output wire [DW-1:0] stkWrData, // Stack write data
  output wire stkRdEn, // Stack read pulse
  output wire [AW-1:0] stkRdAddr, // Stack read address
  output wire vecRdReq, // Vector read request
  output wire [AW-1:0] vecRdAddr, // Vector read address
  output wire cpuReady // Vector loaded, ops accepted
);

  // ----
  // Functions
  // ----
  // Sign-extend a byte to an address-wide offset
  function [15:0] sext16;
    input [7:0] b;
    begin
      sext16 = {{8{b[7]}}, b};
    end
  endfunction

  // X data ops; returns {carry, result}
  function [8:0] xByteOp;
    input [4:0] op;
    input [7:0] v;
    input c;
    begin
      case (op)
        `CPR_OP_CLR_X: xByteOp = {c, 8'h00};
        `CPR_OP_INC_X: xByteOp = {c, v + 8'h01};
        `CPR_OP_DEC_X: xByteOp = {c, v - 8'h01};
        `CPR_OP_COM_X: xByteOp = {1'b1, ~v};
        `CPR_OP_NEG_X: xByteOp = {(v != 8'h00), 8'h00 - v};
        `CPR_OP_LSL_X: xByteOp = {v[7], v[6:0], 1'b0};
        `CPR_OP_LSR_X: xByteOp = {v[0], 1'b0, v[7:1]};
        `CPR_OP_ASR_X: xByteOp = {v[0], v[7], v[7:1]};
        `CPR_OP_ROL_X: xByteOp = {v[7], v[6:0], c};
        `CPR_OP_ROR_X: xByteOp = {v[0], c, v[7:1]};
        default: xByteOp = {c, v};
      endcase
    end
  endfunction

  // ----
  // State and registers
  // ----
  localparam [2:0] ST_VEC_HI = 3'b001; // Reading high vector byte
  localparam [2:0] ST_VEC_LO = 3'b010; // Reading low vector byte
  localparam [2:0] ST_RUN = 3'b100; // Normal operation

  reg [2:0] state_q; // Vector load sequencer
  reg [2:0] state_d;
  reg [DW-1:0] acc_q; // Accumulator, never reset
  reg [DW-1:0] acc_d;
  reg [DW-1:0] idxLo_q; // Lower index byte, never reset
  reg [DW-1:0] idxLo_d;
  reg [DW-1:0] idxHi_q; // Upper index byte
  reg [DW-1:0] idxHi_d;
  reg [AW-1:0] stk_q; // Stack pointer
  reg [AW-1:0] stk_d;
  reg [AW-1:0] fetch_q; // Next fetch address
  reg [AW-1:0] fetch_d;
  reg carry_q; // Carry from last X op
  reg carry_d;
  reg [AW-1:0] ea_q; // Registered effective address
  reg eaValid_q; // Effective address valid
  reg stkWrEn_q; // Stack write strobe
  reg stkWrEn_d;
  reg [AW-1:0] stkWrAddr_q; // Stack write address
  reg [DW-1:0] stkWrData_q; // Stack write data
  reg [DW-1:0] stkWrData_d;
  reg stkRdEn_q; // Stack read strobe
  reg stkRdEn_d;
  reg [AW-1:0] stkRdAddr_q; // Stack read address
  reg [AW-1:0] vecRdAddr_q; // Vector read address

  wire opTake; // Operation accepted this cycle
  wire [AW-1:0] hxPtr; // Combined index pointer
  wire [AW-1:0] eaComb; // Address generator output
  wire postInc; // Mode steps the index pointer
  wire [AW-1:0] hxInc; // Index pointer plus one
  wire [8:0] xRes; // X op result with carry

  // Ops wait until the reset vector is in the fetch pointer
  assign opTake = opValid & state_q[2];
  assign hxPtr = {idxHi_q, idxLo_q}; // see RQ5
  assign hxInc = hxPtr + 16'h0001;
  assign xRes = xByteOp(regOp, idxLo_q, carry_q);

  // ----
  // Address generator
  // ----
  cpr_addr_gen #(
    .AW(AW)
  ) u_addr_gen (
    .addrMode(addrMode),
    .opHi(opHi),
    .opLo(opLo),
    .hxPtr(hxPtr),
    .stkPtr(stk_q),
    .effAddr(eaComb),
    .postInc(postInc)
  );

  // ----
  // Next-state logic
  // ----
  // No address decode exists here: only regOp, post-increment, fetch stepping, branches and vector reads reach these registers
  always @* begin
    acc_d = acc_q;
    idxLo_d = idxLo_q;
    idxHi_d = idxHi_q;
    stk_d = stk_q;
    fetch_d = fetch_q;
    carry_d = carry_q;
    stkWrEn_d = 1'b0;
    stkWrData_d = stkWrData_q;
    stkRdEn_d = 1'b0;
    state_d = state_q;
    // Post-increment first, so an explicit op on the pointer overrides it
    if (addrReq && postInc && state_q[2]) begin
      idxLo_d = hxInc[7:0]; // see RQ17
      idxHi_d = hxInc[15:8];
    end
    // Fetch stepping and branches; an explicit fetch load below wins
    if (state_q[2]) begin
      if (branchTake) begin
        fetch_d = fetch_q + sext16(branchOfs); // see RQ16
      end else if (fetchAdv) begin
        fetch_d = fetch_q + 16'h0001; // see RQ19
      end
    end
    case (state_q)
      ST_VEC_HI: begin
        if (vecRdValid) begin
          fetch_d = {memData, fetch_q[7:0]}; // see RQ19
          state_d = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        if (vecRdValid) begin
          fetch_d = {fetch_q[15:8], memData}; // see RQ19
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_VEC_HI;
      end
    endcase
    if (opTake) begin // see RQ1
      case (regOp)
        `CPR_OP_LOAD_ACC: acc_d = memData; // see RQ3
        `CPR_OP_ALU_WB: acc_d = aluResult; // see RQ2
        `CPR_OP_LOAD_IDX_LO: idxLo_d = memData; // see RQ6
        `CPR_OP_LOAD_IDX_HI: idxHi_d = memData;
        `CPR_OP_CLR_X, `CPR_OP_INC_X, `CPR_OP_DEC_X, `CPR_OP_COM_X,
        `CPR_OP_NEG_X, `CPR_OP_LSL_X, `CPR_OP_LSR_X, `CPR_OP_ASR_X,
        `CPR_OP_ROL_X, `CPR_OP_ROR_X: begin
          idxLo_d = xRes[7:0]; // see RQ7
          carry_d = xRes[8];
        end
        `CPR_OP_ACC_TO_X: idxLo_d = acc_q; // see RQ7
        `CPR_OP_X_TO_ACC: acc_d = idxLo_q; // see RQ7
        `CPR_OP_STK_ADJ: stk_d = stk_q + sext16(opLo); // see RQ12
        `CPR_OP_STK_LOW_REINIT: begin
          stk_d = {stk_q[15:8], `CPR_STK_LOW_REINIT}; // see RQ13
        end
        `CPR_OP_PUSH_ACC, `CPR_OP_PUSH_X, `CPR_OP_PUSH_H, `CPR_OP_PUSH_RET_LO,
        `CPR_OP_PUSH_RET_HI, `CPR_OP_PUSH_EXT: begin
          // Write at the free slot, then move down
          stkWrEn_d = 1'b1; // see RQ9
          stk_d = stk_q - 16'h0001; // see RQ20
          case (regOp)
            `CPR_OP_PUSH_ACC: stkWrData_d = acc_q;
            `CPR_OP_PUSH_X: stkWrData_d = idxLo_q;
            `CPR_OP_PUSH_H: stkWrData_d = idxHi_q;
            `CPR_OP_PUSH_RET_LO: stkWrData_d = fetch_q[7:0]; // see RQ10
            `CPR_OP_PUSH_RET_HI: stkWrData_d = fetch_q[15:8]; // see RQ10
            default: stkWrData_d = extPushData; // see RQ10
          endcase
        end
        `CPR_OP_PULL_INC: begin
          stk_d = stk_q + 16'h0001; // see RQ9
          stkRdEn_d = 1'b1;
        end
        `CPR_OP_LOAD_FETCH_HI: fetch_d = {memData, fetch_q[7:0]};
        `CPR_OP_LOAD_FETCH_LO: fetch_d = {fetch_q[15:8], memData};
        `CPR_OP_LOAD_STK16: stk_d = {opHi, opLo};
        `CPR_OP_LOAD_IDX16: begin
          idxHi_d = opHi; // see RQ5
          idxLo_d = opLo;
        end
        `CPR_OP_JUMP: fetch_d = {opHi, opLo}; // see RQ14
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  // ----
  // Data registers without reset
  // ----
  // Left out of reset on purpose: software may rely on old contents
  always @(posedge sys_clk) begin
    acc_q <= acc_d; // see RQ4
    idxLo_q <= idxLo_d; // see RQ8
  end

  // ----
  // Registers with reset
  // ----
  // Pointers and control state take fixed values under reset
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_VEC_HI;
      idxHi_q <= `CPR_IDX_HI_RESET; // see RQ8
      stk_q <= `CPR_STK_RESET; // see RQ11
      fetch_q <= `CPR_FETCH_RESET;
      carry_q <= 1'b0;
      stkWrEn_q <= 1'b0;
      stkWrData_q <= 8'h00;
      stkRdEn_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idxHi_q <= idxHi_d;
      stk_q <= stk_d;
      fetch_q <= fetch_d;
      carry_q <= carry_d;
      stkWrEn_q <= stkWrEn_d;
      stkWrData_q <= stkWrData_d;
      stkRdEn_q <= stkRdEn_d;
    end
  end

  // ----
  // Address registers
  // ----
  // Addresses registered one cycle after the request
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ea_q <= 16'h0000;
      eaValid_q <= 1'b0;
      stkWrAddr_q <= 16'h0000;
      stkRdAddr_q <= 16'h0000;
      vecRdAddr_q <= `CPR_VEC_HI_ADDR; // see RQ19
    end else begin
      eaValid_q <= addrReq & state_q[2];
      if (addrReq && state_q[2]) begin
        ea_q <= eaComb; // see RQ3
      end
      if (stkWrEn_d) begin
        stkWrAddr_q <= stk_q; // see RQ20
      end
      if (stkRdEn_d) begin
        stkRdAddr_q <= stk_d;
      end
      // Second vector byte sits one address higher
      if (state_q[0] && vecRdValid) begin
        vecRdAddr_q <= `CPR_VEC_LO_ADDR;
      end
    end
  end

  // ----
  // Outputs
  // ----
  assign aluOperandA = acc_q; // see RQ2
  assign storeData = acc_q; // see RQ3
  assign idxPtr = hxPtr;
  assign stkPtr = stk_q;
  assign nextFetchAddr = fetch_q;
  assign effAddr = ea_q;
  assign effValid = eaValid_q;
  assign xCarryOut = carry_q;
  assign stkWrEn = stkWrEn_q;
  assign stkWrAddr = stkWrAddr_q;
  assign stkWrData = stkWrData_q;
  assign stkRdEn = stkRdEn_q;
  assign stkRdAddr = stkRdAddr_q;
  // Handshake from the state bits directly
  assign vecRdReq = state_q[0] | state_q[1];
  assign vecRdAddr = vecRdAddr_q;
  assign cpuReady = state_q[2];

endmodule

// *** tb/cpr_regs_asserts.sv ***
// Concurrent checks on the CPU register file, seeing only its ports.
// Assumes cpr_map.vh on the include path and a single clock domain.
`include "cpr_map.vh"

module cpr_regs_asserts (
  input logic sys_clk, // System clock
  input logic arst_n, // Async reset, active low
  input logic opValid, // Operation strobe
  input logic [4:0] regOp, // Operation code
  input logic [7:0] opLo, // Operand low byte
  input logic addrReq, // Address request
  input logic [3:0] addrMode, // Addressing mode
  input logic fetchAdv, // Fetch step
  input logic branchTake, // Branch strobe
  input logic [7:0] branchOfs, // Branch offset
  input logic vecRdValid, // Vector byte valid
  input logic [7:0] memData, // Memory data
  input logic [7:0] aluOperandA, // Accumulator
  input logic [15:0] idxPtr, // Index pointer
  input logic [15:0] stkPtr, // Stack pointer
  input logic [15:0] nextFetchAddr, // Fetch pointer
  input logic [15:0] effAddr, // Effective address
  input logic effValid, // Address valid
  input logic stkWrEn, // Stack write
  input logic [15:0] stkWrAddr, // Stack write address
  input logic [7:0] stkWrData, // Stack write data
  input logic vecRdReq, // Vector request
  input logic [15:0] vecRdAddr, // Vector address
  input logic cpuReady // Ops accepted
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----
  // Common clocking and qualifiers
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire opTaken = opValid && cpuReady; // Op accepted this edge
  wire adTaken = addrReq && cpuReady && !opValid; // Address request without op clash

  // Vector fetch steps: high byte answered, then low byte
  sequence vecHiTaken;
    vecRdReq && vecRdValid && vecRdAddr == 16'hfffe;
  endsequence
  sequence vecLoTaken;
    vecRdReq && vecRdValid && vecRdAddr == 16'hffff;
  endsequence

  // ----
  // Properties
  // ----
  push_write_a:
  assert property (opTaken && regOp == `CPR_OP_PUSH_ACC |=> stkWrEn && stkWrAddr == $past(stkPtr)
    && stkWrData == $past(aluOperandA) && stkPtr == $past(stkPtr) - 16'h1)
    else $error("push did not write at the free slot");
  stack_adjust_a:
  assert property (opTaken && regOp == `CPR_OP_STK_ADJ |=>
    stkPtr == $past(stkPtr) + {{8{$past(opLo[7])}}, $past(opLo)})
    else $error("stack adjust sum wrong");
  low_reinit_a:
  assert property (opTaken && regOp == `CPR_OP_STK_LOW_REINIT |=>
    stkPtr == {$past(stkPtr[15:8]), `CPR_STK_LOW_REINIT})
    else $error("low reinit touched the high byte");
  refused_op_a:
  assert property (opValid && !cpuReady |=> !stkWrEn && $stable(stkPtr))
    else $error("op acted before ready");
  direct_page_a:
  assert property (adTaken && addrMode == `CPR_AM_DIRECT |=> effValid
    && effAddr == {8'h00, $past(opLo)})
    else $error("direct address left page zero");
  stack_rel_a:
  assert property (adTaken && addrMode == `CPR_AM_STK1 |=> effValid
    && effAddr == $past(stkPtr) + {8'h00, $past(opLo)})
    else $error("stack relative address wrong");
  post_inc_a:
  assert property (adTaken && addrMode == `CPR_AM_IX_POST |=> effValid
    && effAddr == $past(idxPtr) && idxPtr == $past(idxPtr) + 16'h1)
    else $error("post increment mode wrong");
  fetch_step_a:
  assert property (cpuReady && fetchAdv && !branchTake && !opValid |=>
    nextFetchAddr == $past(nextFetchAddr) + 16'h1)
    else $error("fetch pointer did not step");
  branch_rel_a:
  assert property (cpuReady && branchTake && !opValid |=>
    nextFetchAddr == $past(nextFetchAddr) + {{8{$past(branchOfs[7])}}, $past(branchOfs)})
    else $error("branch target wrong");
  vector_hi_a:
  assert property (vecHiTaken |=> vecRdReq && vecRdAddr == 16'hffff && !cpuReady)
    else $error("vector low byte not requested");
  vector_lo_a:
  assert property (vecLoTaken |=> cpuReady && !vecRdReq && nextFetchAddr[7:0] == $past(memData))
    else $error("vector load did not finish");
endmodule

bind cpr_regs cpr_regs_asserts u_chk (
  .sys_clk, .arst_n, .opValid, .regOp, .opLo, .addrReq, .addrMode, .fetchAdv, .branchTake,
  .branchOfs, .vecRdValid, .memData, .aluOperandA, .idxPtr, .stkPtr, .nextFetchAddr,
  .effAddr, .effValid, .stkWrEn, .stkWrAddr, .stkWrData, .vecRdReq, .vecRdAddr, .cpuReady
);

// *** tb/cpr_regs_bench.sv ***
// Self-checking bench for the CPU register file.
// Assumes cpr_map.vh on the include path; inputs move on the falling edge.
`include "cpr_map.vh"

module cpr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, arst_n, opValid, carryIn, addrReq, fetchAdv, branchTake, vecRdValid;
  logic [4:0] regOp; // Op code
  logic [3:0] addrMode; // Mode code
  logic [7:0] opHi, opLo, memData, aluResult, extPushData, branchOfs;
  wire [7:0] aluOperandA, storeData, stkWrData;
  wire [15:0] idxPtr, stkPtr, nextFetchAddr, effAddr, stkWrAddr, stkRdAddr, vecRdAddr;
  wire effValid, xCarryOut, stkWrEn, stkRdEn, vecRdReq, cpuReady;
  integer fails, n_compared, seed, i;
  logic [7:0] acc, xl, xh; // Reference registers
  logic cy; // Reference rotate carry
  logic [15:0] sp, pc; // Reference pointers
  int selQ[$]; // Which output a note is about
  logic [31:0] expQ[$]; // Expected value of that output
  string names[8] = '{"stkPtr", "idxPtr", "nextFetchAddr", "effAddr", "acc", "stkWr", "stkRd",
    "xCarryOut"};

  cpr_regs DUT (
    .sys_clk, .arst_n, .opValid, .regOp, .opHi, .opLo, .memData, .aluResult, .extPushData,
    .carryIn, .addrReq, .addrMode, .fetchAdv, .branchTake, .branchOfs, .vecRdValid,
    .aluOperandA, .storeData, .idxPtr, .stkPtr, .nextFetchAddr, .effAddr, .effValid,
    .xCarryOut, .stkWrEn, .stkWrAddr, .stkWrData, .stkRdEn, .stkRdAddr, .vecRdReq, .vecRdAddr,
    .cpuReady
  );

  // ----
  // Clock, watchdog, compare helpers
  // ----
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run is about 130 cycles; over twenty times that means a hang
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    give_verdict;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic void note(input int s, input logic [31:0] v);
    selQ.push_back(s);
    expQ.push_back(v);
  endfunction

  function automatic logic [7:0] r8;
    r8 = $random(seed);
  endfunction

  function automatic logic [31:0] obs(input int s);
    case (s)
      0: obs = {16'h0, stkPtr};
      1: obs = {16'h0, idxPtr};
      2: obs = {16'h0, nextFetchAddr};
      3: obs = {15'h0, effValid, effAddr};
      4: obs = {16'h0, storeData, aluOperandA};
      5: obs = {7'h0, stkWrEn, stkWrData, stkWrAddr};
      6: obs = {15'h0, stkRdEn, stkRdAddr};
      default: obs = {31'h0, xCarryOut};
    endcase
  endfunction

  // Notes made before an edge are judged at the falling edge after it
  initial begin
    int n, s;
    forever begin
      @(posedge sys_clk);
      n = selQ.size();
      @(negedge sys_clk);
      repeat (n) begin
        s = selQ.pop_front();
        check(names[s], obs(s), expQ.pop_front());
      end
    end
  end

  // ----
  // Drivers with the reference model
  // ----
  task automatic xop(input logic [4:0] c);
    case (c)
      `CPR_OP_CLR_X: xl = 8'h00;
      `CPR_OP_INC_X: xl = xl + 8'h01;
      `CPR_OP_DEC_X: xl = xl - 8'h01;
      `CPR_OP_COM_X: {cy, xl} = {1'b1, ~xl};
      `CPR_OP_NEG_X: {cy, xl} = {xl != 8'h00, -xl};
      `CPR_OP_LSL_X: {cy, xl} = {xl, 1'b0};
      `CPR_OP_LSR_X: {xl, cy} = {1'b0, xl};
      `CPR_OP_ASR_X: {xl, cy} = {xl[7], xl};
      `CPR_OP_ROL_X: {cy, xl} = {xl, cy};
      `CPR_OP_ROR_X: {xl, cy} = {cy, xl};
      `CPR_OP_ACC_TO_X: xl = acc;
      default: ; // Unknown codes change nothing
    endcase
  endtask

  // Stack grows down: write at the free slot, then step
  task automatic push(input logic [7:0] w);
    note(5, {7'h0, 1'b1, w, sp});
    sp = sp - 16'h1;
  endtask

  task automatic op(input logic [4:0] c, input logic [7:0] d);
    logic [7:0] hi;
    hi = r8();
    @(negedge sys_clk);
    {opValid, regOp, opHi, opLo, memData, aluResult, extPushData} = {1'b1, c, hi, d, d, d, d};
    {addrReq, fetchAdv, branchTake, carryIn} = {3'b000, hi[0]};
    case (c)
      `CPR_OP_LOAD_ACC, `CPR_OP_ALU_WB: acc = d;
      `CPR_OP_X_TO_ACC: acc = xl;
      `CPR_OP_LOAD_IDX_LO: xl = d;
      `CPR_OP_LOAD_IDX_HI: xh = d;
      `CPR_OP_LOAD_IDX16: {xh, xl} = {hi, d};
      `CPR_OP_STK_ADJ: sp = sp + {{8{d[7]}}, d};
      `CPR_OP_STK_LOW_REINIT: sp[7:0] = `CPR_STK_LOW_REINIT;
      `CPR_OP_LOAD_STK16: sp = {hi, d};
      `CPR_OP_PULL_INC: begin
        sp = sp + 16'h1;
        note(6, {15'h0, 1'b1, sp});
      end
      `CPR_OP_LOAD_FETCH_HI: pc[15:8] = d;
      `CPR_OP_LOAD_FETCH_LO: pc[7:0] = d;
      `CPR_OP_JUMP: pc = {hi, d};
      `CPR_OP_PUSH_ACC: push(acc);
      `CPR_OP_PUSH_X: push(xl);
      `CPR_OP_PUSH_H: push(xh);
      `CPR_OP_PUSH_RET_LO: push(pc[7:0]);
      `CPR_OP_PUSH_RET_HI: push(pc[15:8]);
      `CPR_OP_PUSH_EXT: push(d);
      default: xop(c);
    endcase
    note(0, {16'h0, sp});
    note(1, {16'h0, xh, xl});
    note(2, {16'h0, pc});
    note(4, {16'h0, acc, acc});
    note(7, {31'h0, cy});
  endtask

  task automatic addr(input logic [3:0] m);
    logic [15:0] hx, ea, k;
    hx = {xh, xl};
    k = {r8(), r8()};
    @(negedge sys_clk);
    {opValid, fetchAdv, branchTake, addrReq, addrMode, opHi, opLo} = {3'b000, 1'b1, m, k};
    case (m)
      `CPR_AM_DIRECT: ea = {`CPR_DIRECT_PAGE, k[7:0]};
      `CPR_AM_EXTENDED: ea = k;
      `CPR_AM_IX, `CPR_AM_IX_POST: ea = hx;
      `CPR_AM_IX1, `CPR_AM_IX1_POST: ea = hx + {8'h00, k[7:0]};
      `CPR_AM_IX2: ea = hx + k;
      `CPR_AM_STK1: ea = sp + {8'h00, k[7:0]};
      default: ea = sp + k;
    endcase
    if (m == `CPR_AM_IX_POST || m == `CPR_AM_IX1_POST) {xh, xl} = hx + 16'h1;
    note(3, {15'h0, 1'b1, ea});
    note(1, {16'h0, xh, xl});
  endtask

  // Branch wins over a plain step
  task automatic fet(input logic adv, input logic br);
    logic [7:0] o;
    o = r8();
    @(negedge sys_clk);
    {opValid, addrReq, fetchAdv, branchTake, branchOfs} = {2'b00, adv, br, o};
    pc = br ? pc + {{8{o[7]}}, o} : pc + {15'h0, adv};
    note(2, {16'h0, pc});
  endtask

  task automatic idle;
    @(negedge sys_clk);
    {opValid, addrReq, fetchAdv, branchTake} = 4'h0;
  endtask

  // Reset, then answer both vector reads; an op offered early is refused
  task automatic boot;
    logic [15:0] v;
    v = {r8(), r8()};
    @(negedge sys_clk);
    arst_n = 0;
    {opValid, addrReq, fetchAdv, branchTake, vecRdValid} = 5'h00;
    repeat (2) @(negedge sys_clk);
    {sp, xh, cy} = {`CPR_STK_RESET, `CPR_IDX_HI_RESET, 1'b0};
    check("stkPtr", {16'h0, stkPtr}, {16'h0, sp});
    check("idxPtr", {16'h0, idxPtr}, {16'h0, xh, xl});
    check("aluOperandA", {24'h0, aluOperandA}, {24'h0, acc});
    check("vecRd", {15'h0, vecRdReq, vecRdAddr}, {15'h0, 1'b1, `CPR_VEC_HI_ADDR});
    arst_n = 1;
    {opValid, regOp, opLo} = {1'b1, `CPR_OP_STK_ADJ, 8'h40};
    @(negedge sys_clk);
    {vecRdValid, memData} = {1'b1, v[15:8]};
    @(negedge sys_clk);
    check("vecRdAddr", {16'h0, vecRdAddr}, {16'h0, `CPR_VEC_LO_ADDR});
    memData = v[7:0];
    @(negedge sys_clk);
    {vecRdValid, opValid} = 2'b00;
    i = 0;
    while (cpuReady !== 1'b1 && i < 4) begin
      @(negedge sys_clk);
      i++;
    end
    pc = v;
    check("ready", {15'h0, cpuReady, nextFetchAddr}, {15'h0, 1'b1, pc});
    check("stkPtr", {16'h0, stkPtr}, {16'h0, sp});
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    seed = 32'h0b71;
    {fails, n_compared} = 0;
    {arst_n, opValid, carryIn, addrReq, fetchAdv, branchTake, vecRdValid} = 7'h00;
    {regOp, addrMode, opHi, opLo, memData, aluResult, extPushData, branchOfs} = 0;
    boot;
    op(`CPR_OP_LOAD_ACC, r8());
    op(`CPR_OP_LOAD_IDX_HI, r8());
    op(`CPR_OP_LOAD_IDX_LO, r8());
    op(`CPR_OP_ALU_WB, r8());
    for (i = `CPR_OP_CLR_X; i <= `CPR_OP_X_TO_ACC; i++) begin
      repeat (3) begin
        op(`CPR_OP_LOAD_IDX_LO, r8());
        op(i[4:0], 8'h00);
      end
    end
    op(`CPR_OP_LOAD_IDX_LO, 8'h00);
    op(`CPR_OP_NEG_X, 8'h00);
    op(5'h1f, r8());
    op(`CPR_OP_LOAD_STK16, r8());
    op(`CPR_OP_STK_ADJ, 8'h80);
    op(`CPR_OP_STK_ADJ, 8'h7f);
    op(`CPR_OP_STK_LOW_REINIT, 8'h00);
    for (i = `CPR_OP_PUSH_ACC; i <= `CPR_OP_PUSH_EXT; i++) op(i[4:0], r8());
    repeat (2) op(`CPR_OP_PULL_INC, 8'h00);
    op(`CPR_OP_LOAD_IDX16, r8());
    for (i = 0; i <= 8; i++) addr(i[3:0]);
    op(`CPR_OP_LOAD_IDX_LO, 8'hff);
    addr(`CPR_AM_IX_POST);
    addr(`CPR_AM_IX1_POST);
    repeat (2) fet(1'b1, 1'b0);
    fet(1'b0, 1'b1);
    fet(1'b1, 1'b1);
    op(`CPR_OP_JUMP, r8());
    op(`CPR_OP_LOAD_FETCH_HI, r8());
    op(`CPR_OP_LOAD_FETCH_LO, r8());
    op(`CPR_OP_NOP, 8'h00);
    idle;
    boot;
    idle;
    repeat (2) @(negedge sys_clk);
    give_verdict;
  end

  task give_verdict;
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
endmodule
